// ===== verilog/gauge_cmd_pkg.sv
// Purpose: Shared constants and types of the gauge maintenance command unit
// Assumes: Core clock 20 MHz, link sampling clock period 160 ns
// Notes:   Long cycle counts are derived and overridable at the top; link counts here
package gauge_cmd_pkg;

    // Register codes, shared by the two-wire and the one-wire port
    localparam logic [7:0]  REG_MAINT   = 8'h00;
    localparam logic [7:0]  REG_LOWCAP  = 8'h01;

    // Maintenance command words
    localparam logic [15:0] CMD_STORAGE = 16'h0618;
    localparam logic [15:0] CMD_SEAL    = 16'h062B;
    localparam logic [15:0] CMD_CHGSYNC = 16'h064D;
    localparam logic [15:0] CMD_CAL     = 16'h0653;
    localparam logic [15:0] CMD_CALALT  = 16'h067E;
    localparam logic [15:0] CMD_CALSTOP = 16'h0660;
    localparam logic [15:0] CMD_EEPROM  = 16'h0606;

    // Bus addresses, alarm flag word, one-wire write bit and percent divisor
    localparam logic [7:0]  BATTERY_ADDR    = 8'h16;
    localparam logic [7:0]  HOST_ADDR       = 8'h10;
    localparam logic [7:0]  CHARGER_ADDR    = 8'h12;
    localparam logic [15:0] LOWCAP_ALARM    = 16'h0200;
    localparam logic        OW_WRITE_BIT    = 1'b1;
    localparam logic [23:0] PCT_DIV         = 24'h000064;

    // Core timing, in milliseconds and core clock kilohertz
    localparam longint unsigned CLK_KHZ         = 20000;
    localparam longint unsigned HOLDOFF_MS      = 1000;
    localparam longint unsigned STORE_DELAY_MS  = 6000;
    localparam longint unsigned CAL_LIMIT_MS    = 3600000;
    localparam longint unsigned POST_CAL_MS     = 20000;
    localparam longint unsigned ALARM_PERIOD_MS = 10000;

    // Link timing, in nanoseconds of the 160 ns sampling clock
    localparam longint unsigned LINK_PERIOD_NS  = 160;
    localparam longint unsigned BIT_TIMEOUT_NS  = 250000;
    localparam longint unsigned BREAK_NS        = 190000;
    localparam longint unsigned RECOVERY_NS     = 40000;
    localparam longint unsigned ONE_MAX_NS      = 50000;
    localparam logic [11:0] BIT_TIMEOUT_CYC =
        12'(BIT_TIMEOUT_NS / LINK_PERIOD_NS);
    localparam logic [11:0] BREAK_CYC =
        12'((BREAK_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
    localparam logic [11:0] RECOVERY_CYC =
        12'((RECOVERY_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
    localparam logic [11:0] ONE_MAX_CYC =
        12'(ONE_MAX_NS / LINK_PERIOD_NS);

    typedef enum logic [1:0] {RX_RECOVER, RX_HIGH, RX_LOW, RX_BREAK} rx_state_t;
    typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_SAVE} cal_state_t;
    typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_CHAIN, ST_POST,
                              ST_SLEEP} store_state_t;

    typedef struct packed {
        logic [7:0]  cmd;
        logic [15:0] data;
    } ow_frame_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] word;
    } alarm_msg_t;

endpackage

// ===== verilog/gauge_maintenance_command_unit.sv
// Purpose: Maintenance command interpreter with one-wire receiver and alarm
// Assumes: Two-wire front end delivers decoded word strobes on core_clk
// Notes:   One-wire read frames are not answered; the pin is never driven
// Functional notes
// - Maintenance commands within one second after reset may be ignored.
// - Storage command enters storage after 5-8 s, other commands still taken.
// - Command word cleared within 900 ms after storage command.
// - Calibration during storage delay postpones storage until results saved.
// - Seal command restricts access and clears the word within 900 ms.
// - Charge sync sets remaining charge to percent of full charge value.
// - Calibration command disconnects sense inputs, corrects chip offset only.
// - Alternate calibration keeps sense inputs, corrects chip and board.
// - Calibrating blanks display; only stop and seal commands taken.
// - Calibration ends by itself, saves results, capped at one hour.
// - Calibration start clears word within 900 ms, starts within 3.2 s.
// - Stop command aborts calibration within 20 ms, disables correction.
// - Program command routes bus to EEPROM, powers it, suspends monitoring.
// - Battery address seen on bus drops the EEPROM route.
// - Calibration-done bit clears at start, sets on successful completion.
// - Chained calibration enters storage about 20 s after completion.
// - One-wire break resets receiver, then recovery high, then await command.
// - Remaining charge below nonzero threshold sends low-capacity alarms.
// - Threshold loaded from EEPROM value at reset, kept until written.
// - Threshold unit follows capacity mode bit, range 0 to 65535.
// - One-wire frame: 7-bit code, R/W bit, 16-bit data, LSB first.
// - Alarms are Write Word messages to host 0x10 and charger 0x12.
`timescale 1ns/1ns
`default_nettype none
module gauge_maintenance_command_unit
    import gauge_cmd_pkg::*;
#(
    parameter logic [24:0] HOLDOFF_CYC     = 25'(HOLDOFF_MS * CLK_KHZ),
    parameter logic [28:0] STORE_DELAY_CYC = 29'(STORE_DELAY_MS * CLK_KHZ),
    parameter logic [36:0] CAL_LIMIT_CYC   = 37'(CAL_LIMIT_MS * CLK_KHZ),
    parameter logic [28:0] POST_CAL_CYC    = 29'(POST_CAL_MS * CLK_KHZ),
    parameter logic [27:0] ALARM_CYC       = 28'(ALARM_PERIOD_MS * CLK_KHZ)
) (
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic        oneWireClk,
    input  wire logic        oneWirePinIn,
    output logic             oneWirePinOut,
    output logic             oneWirePinOe,
    input  wire logic        smbWrStb,
    input  wire logic        smbRdStb,
    input  wire logic [7:0]  smbCmd,
    input  wire logic [15:0] smbWrData,
    input  wire logic        smbAddrStb,
    input  wire logic [7:0]  smbAddrByte,
    output logic [15:0]      smbRdData,
    output logic             smbRdValid,
    input  wire logic [15:0] remainingCharge,
    input  wire logic [15:0] fullChargeValue,
    input  wire logic [7:0]  fastChgTermPct,
    input  wire logic        capacityMode,
    input  wire logic [15:0] eeThreshold,
    input  wire logic        convCalDone,
    input  wire logic        calSaveAck,
    input  wire logic        alarmAck,
    output logic             sealed,
    output logic             storageEnter,
    output logic             ledBlank,
    output logic             calActive,
    output logic             senseDisconnect,
    output logic             offsetCorrEn,
    output logic             offsetCalDone,
    output logic             calSaveReq,
    output logic             eepromRoute,
    output logic             eepromPower,
    output logic             monitorSuspend,
    output logic             chgLoadStb,
    output logic [15:0]      chgLoadValue,
    output logic             thresholdMwh,
    output logic             alarmReq,
    output alarm_msg_t       alarmMsg
);

    typedef struct packed {
        logic        rstS1;
        logic        rstS2;
        logic        pinS1;
        logic        pinS2;
        rx_state_t   rx;
        logic [11:0] cnt;
        logic [4:0]  bitCnt;
        logic [23:0] shift;
        ow_frame_t   frame;
        logic        frameTgl;
    } link_state_t;

    typedef struct packed {
        logic         tglS1;
        logic         tglS2;
        logic         tglS3;
        logic         loadPend;
        logic [24:0]  holdCnt;
        logic [15:0]  maint;
        logic         clrPend;
        logic [15:0]  lowCap;
        logic         unitMwh;
        logic         sealed;
        cal_state_t   calSt;
        logic         calActive;
        logic         calAlt;
        logic [36:0]  calCnt;
        logic         calDone;
        logic         offCorr;
        logic         saveReq;
        store_state_t storeSt;
        logic [28:0]  storeCnt;
        logic         sleep;
        logic         route;
        logic [15:0]  rdData;
        logic         rdValid;
        logic         chgStb;
        logic [15:0]  chgVal;
        logic         alarmReq;
        alarm_msg_t   alarmMsg;
        logic         toCharger;
        logic [27:0]  alarmCnt;
    } core_state_t;

    link_state_t l;
    link_state_t ln;
    core_state_t q;
    core_state_t d;

    logic        bitVal;
    logic        owNew;
    logic        wrEn;
    logic [7:0]  wrReg;
    logic [15:0] wrData;
    logic        wrMaint;
    logic        cmdOk;
    logic        calFinish;
    logic        lowCond;
    logic [23:0] prod;

    // Link domain: pin and reset synchronisers, pulse-width bit receiver
    always_comb begin
        ln = l;
        bitVal = 1'b0;
        ln.rstS1 = srst;
        ln.rstS2 = l.rstS1;
        ln.pinS1 = oneWirePinIn;
        ln.pinS2 = l.pinS1;
        if (l.rstS2) begin
            ln.rx = RX_RECOVER;
            ln.cnt = 12'h000;
            ln.bitCnt = 5'h00;
            ln.shift = 24'h000000;
            ln.frame = '0;
            ln.frameTgl = 1'b0;
        end else begin
            case (l.rx)
                RX_RECOVER: begin
                    // Line must stay high for the recovery time
                    if (!l.pinS2) begin
                        ln.cnt = 12'h000;
                    end else if (l.cnt >= RECOVERY_CYC) begin
                        ln.rx = RX_HIGH;
                        ln.cnt = 12'h000;
                        ln.bitCnt = 5'h00;
                    end else begin
                        ln.cnt = l.cnt + 12'h001;
                    end
                end
                RX_HIGH: begin
                    if (!l.pinS2) begin
                        ln.rx = RX_LOW;
                        ln.cnt = 12'h000;
                    end else if (l.cnt >= BIT_TIMEOUT_CYC) begin
                        ln.bitCnt = 5'h00; // Overlong bit cycle drops frame
                    end else begin
                        ln.cnt = l.cnt + 12'h001;
                    end
                end
                RX_LOW: begin
                    if (l.pinS2) begin
                        // Short low pulse is a one; bits arrive LSB first
                        bitVal = (l.cnt < ONE_MAX_CYC);
                        ln.shift[l.bitCnt] = bitVal;
                        ln.rx = RX_HIGH;
                        ln.cnt = 12'h000;
                        ln.bitCnt = l.bitCnt + 5'h01;
                        if (l.bitCnt == 5'h07 && bitVal != OW_WRITE_BIT) begin
                            ln.bitCnt = 5'h00;
                        end
                        if (l.bitCnt == 5'h17) begin
                            ln.frame.cmd = ln.shift[7:0];
                            ln.frame.data = ln.shift[23:8];
                            ln.frameTgl = ~l.frameTgl;
                            ln.bitCnt = 5'h00;
                        end
                    end else if (l.cnt >= BREAK_CYC) begin
                        ln.rx = RX_BREAK;
                        ln.bitCnt = 5'h00;
                    end else begin
                        ln.cnt = l.cnt + 12'h001;
                    end
                end
                RX_BREAK: begin
                    if (l.pinS2) begin
                        ln.rx = RX_RECOVER;
                        ln.cnt = 12'h000;
                    end
                end
                default: ln.rx = RX_RECOVER;
            endcase
        end
    end

    always_ff @(posedge oneWireClk) begin
        l <= ln;
    end

    // Pin is listen-only: reads over the one-wire port are not answered
    assign oneWirePinOut = 1'b0;
    assign oneWirePinOe  = 1'b0;

    // Core domain: merge ports, decode commands, run timers
    always_comb begin
        d = q;
        d.tglS1 = l.frameTgl;
        d.tglS2 = q.tglS1;
        d.rdValid = 1'b0;
        d.chgStb = 1'b0;
        d.unitMwh = capacityMode;
        owNew = q.tglS2 ^ q.tglS3;
        // Two-wire write wins; a pending one-wire frame waits a cycle
        d.tglS3 = smbWrStb ? q.tglS3 : q.tglS2;
        wrEn = smbWrStb | owNew;
        wrReg = smbWrStb ? smbCmd : {1'b0, l.frame.cmd[6:0]};
        wrData = smbWrStb ? smbWrData : l.frame.data;
        wrMaint = wrEn && wrReg == REG_MAINT && q.holdCnt == 25'h0;
        // While calibrating only stop and seal are taken
        cmdOk = !q.calActive || wrData == CMD_CALSTOP
                || wrData == CMD_SEAL;
        calFinish = q.calSt == CAL_SAVE && calSaveAck;
        lowCond = q.lowCap != 16'h0 && remainingCharge < q.lowCap;
        prod = 24'(fullChargeValue) * 24'(fastChgTermPct);

        if (q.holdCnt != 25'h0) begin
            d.holdCnt = q.holdCnt - 25'h1;
        end
        if (q.loadPend) begin
            d.loadPend = 1'b0;
            d.lowCap = eeThreshold;
        end
        // Recognised commands clear a cycle later, except calibrate and program refused when sealed; a new write wins
        if (q.clrPend) begin
            d.clrPend = 1'b0;
            d.maint = 16'h0;
        end
        if (wrEn && wrReg == REG_LOWCAP) begin
            d.lowCap = wrData;
        end
        if (smbRdStb) begin
            d.rdValid = 1'b1;
            d.rdData = (smbCmd == REG_MAINT) ? q.maint :
                       (smbCmd == REG_LOWCAP) ? q.lowCap : 16'h0;
        end

        if (wrMaint && cmdOk) begin
            d.maint = wrData;
            d.clrPend = 1'b0;
            case (wrData)
                CMD_STORAGE: begin
                    d.clrPend = 1'b1;
                    if (q.storeSt == ST_IDLE) begin
                        d.storeSt = ST_WAIT;
                        d.storeCnt = 29'h0;
                    end
                end
                CMD_SEAL: begin
                    d.clrPend = 1'b1;
                    d.sealed = 1'b1;
                end
                CMD_CHGSYNC: begin
                    d.clrPend = 1'b1;
                    d.chgStb = 1'b1;
                    d.chgVal = 16'(prod / PCT_DIV);
                end
                CMD_CAL, CMD_CALALT: begin
                    if (!q.sealed && q.calSt == CAL_IDLE) begin
                        d.clrPend = 1'b1;
                        d.calSt = CAL_RUN;
                        d.calActive = 1'b1;
                        d.calAlt = (wrData == CMD_CALALT);
                        d.calCnt = 37'h0;
                        d.calDone = 1'b0;
                        d.offCorr = 1'b0;
                    end
                end
                CMD_CALSTOP: begin
                    d.clrPend = 1'b1;
                    if (q.calSt == CAL_RUN) begin
                        d.calSt = CAL_IDLE;
                        d.calActive = 1'b0;
                        d.offCorr = 1'b0;
                    end
                end
                CMD_EEPROM: begin
                    if (!q.sealed) begin
                        d.clrPend = 1'b1;
                        d.route = 1'b1;
                    end
                end
                default: d.clrPend = 1'b0;
            endcase
        end

        // Route drops when the battery address shows on the bus
        if (q.route && smbAddrStb && smbAddrByte == BATTERY_ADDR) begin
            d.route = 1'b0;
        end

        // Calibration runs until the converter reports or the cap expires
        case (q.calSt)
            CAL_IDLE: d.saveReq = 1'b0;
            CAL_RUN: begin
                if (d.calSt == CAL_RUN) begin
                    d.calCnt = q.calCnt + 37'h1;
                    if (convCalDone || q.calCnt >= CAL_LIMIT_CYC - 37'h1) begin
                        d.calSt = CAL_SAVE;
                        d.saveReq = 1'b1;
                    end
                end
            end
            CAL_SAVE: begin
                if (calSaveAck) begin
                    d.calSt = CAL_IDLE;
                    d.calActive = 1'b0;
                    d.saveReq = 1'b0;
                    d.calDone = 1'b1;
                    d.offCorr = 1'b1;
                end
            end
            default: d.calSt = CAL_IDLE;
        endcase

        // Storage entry, postponed while a calibration is running
        case (q.storeSt)
            ST_IDLE: d.sleep = 1'b0;
            ST_WAIT: begin
                d.storeCnt = q.storeCnt + 29'h1;
                if (q.calSt != CAL_IDLE) begin
                    d.storeSt = ST_CHAIN;
                end else if (q.storeCnt >= STORE_DELAY_CYC - 29'h1) begin
                    d.storeSt = ST_SLEEP;
                    d.sleep = 1'b1;
                end
            end
            ST_CHAIN: begin
                d.storeCnt = 29'h0;
                if (calFinish) begin
                    d.storeSt = ST_POST;
                end else if (q.calSt == CAL_IDLE) begin
                    d.storeSt = ST_WAIT;
                end
            end
            ST_POST: begin
                d.storeCnt = q.storeCnt + 29'h1;
                if (q.storeCnt >= POST_CAL_CYC - 29'h1) begin
                    d.storeSt = ST_SLEEP;
                    d.sleep = 1'b1;
                end
            end
            ST_SLEEP: d.sleep = 1'b1; // Left only by reset
            default: d.storeSt = ST_IDLE;
        endcase

        // Alarm messages go host first, then charger, then wait a period
        if (q.alarmCnt != 28'h0) begin
            d.alarmCnt = q.alarmCnt - 28'h1;
        end
        if (q.alarmReq) begin
            if (alarmAck) begin
                d.alarmReq = 1'b0;
                d.toCharger = ~q.toCharger;
                d.alarmCnt = q.toCharger ? ALARM_CYC : 28'h0;
            end
        end else if (lowCond && q.alarmCnt == 28'h0 && !q.route
                     && !q.sleep) begin
            d.alarmReq = 1'b1;
            d.alarmMsg.addr = q.toCharger ? CHARGER_ADDR : HOST_ADDR;
            d.alarmMsg.word = LOWCAP_ALARM;
        end

        if (srst) begin
            d = '0;
            d.loadPend = 1'b1;
            d.holdCnt = HOLDOFF_CYC;
        end
    end

    always_ff @(posedge core_clk) begin
        q <= d;
    end

    // Outputs straight from the state flops; senseDisconnect gates calActive with calAlt
    assign smbRdData       = q.rdData;
    assign smbRdValid      = q.rdValid;
    assign sealed          = q.sealed;
    assign storageEnter    = q.sleep;
    assign ledBlank        = q.calActive;
    assign calActive       = q.calActive;
    assign senseDisconnect = q.calActive & ~q.calAlt;
    assign offsetCorrEn    = q.offCorr;
    assign offsetCalDone   = q.calDone;
    assign calSaveReq      = q.saveReq;
    assign eepromRoute     = q.route;
    assign eepromPower     = q.route;
    assign monitorSuspend  = q.route;
    assign chgLoadStb      = q.chgStb;
    assign chgLoadValue    = q.chgVal;
    assign thresholdMwh    = q.unitMwh;
    assign alarmReq        = q.alarmReq;
    assign alarmMsg        = q.alarmMsg;

    sequence cmdTaken;
        wrMaint && cmdOk && q.calSt == CAL_IDLE && wrData == CMD_STORAGE;
    endsequence

    sequence wordCleared;
        ##2 (q.maint == 16'h0 || $past(wrMaint));
    endsequence

    holdoff_quiet_a: assert property (@(posedge core_clk) disable iff (srst)
        q.holdCnt != 25'h0 |-> q.storeSt == ST_IDLE && !q.calActive)
        else $error("command acted on during reset holdoff");

    store_delay_a: assert property (@(posedge core_clk) disable iff (srst)
        $rose(q.sleep) && $past(q.storeSt) == ST_WAIT
        |-> $past(q.storeCnt) == STORE_DELAY_CYC - 29'h1)
        else $error("storage entered at wrong delay");

    storage_clear_a: assert property (@(posedge core_clk) disable iff (srst)
        cmdTaken |-> wordCleared)
        else $error("command word not cleared");

    cal_gate_a: assert property (@(posedge core_clk) disable iff (srst)
        q.calActive && wrMaint && wrData != CMD_CALSTOP
        && wrData != CMD_SEAL && wrData != 16'h0
        |=> q.maint != $past(wrData))
        else $error("command taken during calibration");

    lock_gate_a: assert property (@(posedge core_clk) disable iff (srst)
        q.sealed && wrMaint && (wrData == CMD_CAL || wrData == CMD_EEPROM)
        |=> $stable(q.calSt) && q.route == $past(q.route))
        else $error("locked device took restricted command");

    stop_cal_a: assert property (@(posedge core_clk) disable iff (srst)
        q.calSt == CAL_RUN && wrMaint && wrData == CMD_CALSTOP
        |=> q.calSt == CAL_IDLE && !offsetCorrEn && !ledBlank)
        else $error("stop did not abort calibration");

    cal_done_a: assert property (@(posedge core_clk) disable iff (srst)
        $rose(q.calDone) |-> $past(q.calSt) == CAL_SAVE
        && $past(calSaveAck))
        else $error("done bit set without saved calibration");

    cal_cap_a: assert property (@(posedge core_clk) disable iff (srst)
        q.calCnt <= CAL_LIMIT_CYC)
        else $error("calibration ran past its cap");

    eeprom_drop_a: assert property (@(posedge core_clk) disable iff (srst)
        q.route && smbAddrStb && smbAddrByte == BATTERY_ADDR
        |=> !eepromRoute && !monitorSuspend)
        else $error("route not dropped on battery address");

    alarm_cause_a: assert property (@(posedge core_clk) disable iff (srst)
        $rose(q.alarmReq) |-> $past(q.lowCap) != 16'h0
        && $past(remainingCharge) < $past(q.lowCap))
        else $error("alarm without low capacity");

    break_reset_a: assert property (@(posedge oneWireClk)
        disable iff (l.rstS2)
        l.rx == RX_LOW && l.pinS2 == 1'b0 && l.cnt >= BREAK_CYC
        |=> l.rx == RX_BREAK && l.bitCnt == 5'h00)
        else $error("break not recognised");

endmodule
`default_nettype wire

// ===== verif/one_wire_host.sv
// Purpose: Host model that drives the one-wire link line
// Assumes: Line idles high through the pull-up
// Notes:   Writes only; a short low is a one, a long low a zero
`timescale 1ns/1ns
`default_nettype none
module one_wire_host (
    input  wire logic oneWireClk,
    output var logic  line
);
    initial line = 1'b1; // Idle high, as the pull-up holds it
    // Break first, so a stale partial frame never merges with this one
    task automatic send(input logic [6:0] code, input logic [15:0] word);
        logic [23:0] f;
        f = {word, 1'b1, code};
        @(posedge oneWireClk);
        line <= 1'b0;
        repeat (1200) @(posedge oneWireClk);
        line <= 1'b1;
        repeat (260) @(posedge oneWireClk);
        for (int i = 0; i < 24; i++) begin
            line <= 1'b0;
            repeat (f[i] ? 20 : 400) @(posedge oneWireClk);
            line <= 1'b1;
            repeat (40) @(posedge oneWireClk);
        end
    endtask
endmodule
`default_nettype wire

// ===== verif/test_gauge_maintenance_command_unit.sv
// Purpose: Self-checking bench of the maintenance command unit
// Assumes: Shortened counts at the instance, link clock free running
// Notes:   Storage is left only by reset, so the chained case runs last
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
    mismatches++; $display("BAD %0t %h %h", $time, (a), (b)); end end
module test_gauge_maintenance_command_unit import gauge_cmd_pkg::*; ;
    logic        core_clk, srst, oneWireClk, smbWrStb, smbRdStb, smbAddrStb;
    logic        capacityMode, convCalDone, calSaveAck, alarmAck, owLine;
    logic [7:0]  smbCmd, smbAddrByte, fastChgTermPct;
    logic [15:0] fullChargeValue, eeThreshold;
    logic [15:0] smbWrData, remainingCharge, smbRdData, chgLoadValue;
    logic        smbRdValid, sealed, storageEnter, ledBlank, calActive;
    logic        senseDisconnect, offsetCorrEn, offsetCalDone, calSaveReq;
    logic        eepromRoute, eepromPower, monitorSuspend, chgLoadStb;
    logic        thresholdMwh, alarmReq;
    alarm_msg_t  alarmMsg;
    int          mismatches = 0;
    int          total_checks = 0;
    // Small counts keep the storage and calibration waits short
    gauge_maintenance_command_unit #(.HOLDOFF_CYC(25'd20),
        .STORE_DELAY_CYC(29'd200), .CAL_LIMIT_CYC(37'd500),
        .POST_CAL_CYC(29'd100), .ALARM_CYC(28'd50)) DUT (.*,
        .oneWirePinIn(owLine), .oneWirePinOut(), .oneWirePinOe());
    one_wire_host host (.oneWireClk(oneWireClk), .line(owLine));
    // Clocks, the link one offset so edges never line up
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        oneWireClk = 1'b0;
        #7;
        forever #80 oneWireClk = ~oneWireClk;
    end
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(posedge core_clk);
        smbWrStb <= 1'b1;
        smbCmd <= c;
        smbWrData <= d;
        @(posedge core_clk);
        smbWrStb <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        @(posedge core_clk);
        smbRdStb <= 1'b1;
        smbCmd <= c;
        @(posedge core_clk);
        smbRdStb <= 1'b0;
        #1 `CHK({smbRdValid, smbRdData}, {1'b1, e})
    endtask
    task automatic rst();
        @(posedge core_clk);
        srst <= 1'b1;
        repeat (12) @(posedge core_clk);
        srst <= 1'b0;
    endtask
    task automatic t_basic();
        rd(REG_LOWCAP, 16'h0100);
        wr(REG_MAINT, CMD_CHGSYNC);
        `CHK(chgLoadStb, 1'b0)
        repeat (25) @(posedge core_clk);
        capacityMode <= 1'b1;
        wr(REG_MAINT, CMD_CHGSYNC);
        `CHK({chgLoadStb, chgLoadValue}, {1'b1, 16'h012C})
        rd(REG_MAINT, 16'h0000);
        `CHK(thresholdMwh, 1'b1)
        wr(REG_MAINT, CMD_EEPROM);
        `CHK({eepromRoute, eepromPower, monitorSuspend}, 3'b111)
        @(posedge core_clk);
        smbAddrStb <= 1'b1;
        smbAddrByte <= BATTERY_ADDR;
        @(posedge core_clk);
        smbAddrStb <= 1'b0;
        #1 `CHK({eepromRoute, monitorSuspend}, 2'b00)
        wr(REG_MAINT, CMD_CALALT);
        `CHK({calActive, ledBlank, senseDisconnect}, 3'b110)
        wr(REG_MAINT, CMD_CHGSYNC);
        `CHK(chgLoadStb, 1'b0)
        wr(REG_MAINT, CMD_CALSTOP);
        `CHK({calActive, offsetCorrEn}, 2'b00)
        $display("basic done");
    endtask
    task automatic t_alarm();
        wr(REG_LOWCAP, 16'h0000);
        remainingCharge <= 16'h00FF;
        repeat (4) @(posedge core_clk);
        #1 `CHK(alarmReq, 1'b0)
        wr(REG_LOWCAP, 16'h0100);
        repeat (3) @(posedge core_clk);
        #1 `CHK({alarmReq, alarmMsg}, {1'b1, HOST_ADDR, LOWCAP_ALARM})
        @(posedge core_clk);
        alarmAck <= 1'b1;
        @(posedge core_clk);
        alarmAck <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1 `CHK({alarmReq, alarmMsg}, {1'b1, CHARGER_ADDR, LOWCAP_ALARM})
        alarmAck <= 1'b1;
        @(posedge core_clk);
        alarmAck <= 1'b0;
        remainingCharge <= 16'hFFFF;
        host.send(7'(REG_LOWCAP), 16'h1234);
        repeat (20) @(posedge core_clk);
        rd(REG_LOWCAP, 16'h1234);
        wr(REG_MAINT, CMD_SEAL);
        rd(REG_MAINT, 16'h0000);
        wr(REG_MAINT, CMD_CAL);
        `CHK({sealed, calActive}, 2'b10)
        // Plain storage request, no calibration behind it
        wr(REG_MAINT, CMD_STORAGE);
        repeat (199) @(posedge core_clk);
        #1 `CHK(storageEnter, 1'b0)
        @(posedge core_clk);
        #1 `CHK(storageEnter, 1'b1)
        $display("alarm, link and seal done");
    endtask
    task automatic t_store();
        rd(REG_LOWCAP, 16'h0080);
        repeat (25) @(posedge core_clk);
        wr(REG_MAINT, CMD_STORAGE);
        rd(REG_MAINT, 16'h0000);
        wr(REG_MAINT, CMD_CAL);
        `CHK({calActive, senseDisconnect, offsetCalDone}, 3'b110)
        convCalDone <= 1'b1;
        @(posedge core_clk);
        convCalDone <= 1'b0;
        repeat (200) @(posedge core_clk);
        #1 `CHK({calSaveReq, storageEnter}, 2'b10)
        calSaveAck <= 1'b1;
        @(posedge core_clk);
        calSaveAck <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1 `CHK({calActive, offsetCalDone, offsetCorrEn}, 3'b011)
        repeat (110) @(posedge core_clk);
        #1 `CHK(storageEnter, 1'b1)
        $display("storage done");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Main sequence; the watchdog below allows a little over three times the run
    initial begin
        srst = 1'b1;
        remainingCharge = 16'hFFFF;
        {fullChargeValue, fastChgTermPct} = {16'h0190, 8'h4B};
        eeThreshold = 16'h0100;
        {smbWrStb, smbRdStb, smbAddrStb, convCalDone, calSaveAck} = '0;
        {alarmAck, capacityMode, smbCmd, smbAddrByte, smbWrData} = '0;
        rst();
        t_basic();
        t_alarm();
        eeThreshold <= 16'h0080; // New stored threshold, reloaded by reset
        rst();
        t_store();
        finish_test();
    end
    initial begin
        #5000000;
        mismatches++;
        finish_test();
    end
endmodule
`default_nettype wire
